// ### rtl/dspr_consts.vh
`ifndef DSPR_CONSTS_VH
`define DSPR_CONSTS_VH

// ========================================
// Register byte offsets
`define DSPR_OFS_PRIO       6'h00
`define DSPR_OFS_RDPAGE     6'h04
`define DSPR_OFS_WRPAGE     6'h08
`define DSPR_OFS_MODCTL     6'h0C
`define DSPR_OFS_IRQSTAT    6'h10
`define DSPR_OFS_IRQMASK    6'h14
`define DSPR_OFS_GRANT      6'h18

// ========================================
// Field widths and positions
`define DSPR_RDPAGE_W       10
`define DSPR_WRPAGE_W       9
`define DSPR_MOD_XEN_BIT    15
`define DSPR_MOD_YEN_BIT    14
`define DSPR_MOD_BREV_HI    11
`define DSPR_MOD_BREV_LO    8
`define DSPR_MOD_YSEL_HI    7
`define DSPR_MOD_YSEL_LO    4
`define DSPR_MOD_XSEL_HI    3
`define DSPR_MOD_XSEL_LO    0
`define DSPR_MOD_MASK       16'hCFFF
`define DSPR_BREV_OFF       4'hF
`define DSPR_IRQ_RDTRAP     0
`define DSPR_IRQ_WRTRAP     1

// ========================================
// Reset values
`define DSPR_RST_PRIO       16'h0000
`define DSPR_RST_RDPAGE     10'h001
`define DSPR_RST_WRPAGE     9'h001
`define DSPR_RST_MODCTL     16'h0000
`define DSPR_RST_IRQ        2'h0

`endif

// ### rtl/dspr_regs.v
`timescale 1ns/1ps
`include "dspr_consts.vh"

module dspr_regs
(
    input  wire        mclk,          // Core clock, 200 MHz
    input  wire        rstn,          // Asynchronous reset, active low
    input  wire        ce,            // Clock enable, freezes all state when low
    input  wire        wb_cyc_i,      // Wishbone cycle
    input  wire        wb_stb_i,      // Wishbone strobe
    input  wire        wb_we_i,       // Wishbone write enable
    input  wire [5:0]  wb_adr_i,      // Wishbone byte address
    input  wire [3:0]  wb_sel_i,      // Wishbone byte lanes
    input  wire [31:0] wb_dat_i,      // Wishbone write data
    output wire [31:0] wb_dat_o,      // Wishbone read data
    output wire        wb_ack_o,      // Wishbone acknowledge
    input  wire [4:0]  masterReq,     // Requests: 0 core, 1..3 masters, 4 debugger
    output wire [4:0]  masterGnt,     // One-hot grant
    input  wire        pageRdReq,     // Read access into paged window
    input  wire        pageWrReq,     // Write access into paged window
    output wire        addrErrTrap,   // Address error trap pulse
    output wire [9:0]  readPage,      // Read page pointer in force
    output wire [8:0]  writePage,     // Write page pointer in force
    output wire        xModuloEnable, // X modulo addressing enable
    output wire        yModuloEnable, // Y modulo addressing enable
    output wire [3:0]  bitrevPointerSelect, // Bit-reverse pointer select
    output wire        bitrevActive,  // Bit-reverse addressing selected
    output wire [3:0]  yModuloPointerSelect, // Y modulo pointer select
    output wire [3:0]  xModuloPointerSelect, // X modulo pointer select
    output wire        irq            // Level interrupt
);

    // ========================================
    // Register state
    reg [15:0] prio_r;
    reg [9:0]  rdPage_r;
    reg [8:0]  wrPage_r;
    reg [15:0] modCtl_r;
    reg [1:0]  irqStat_r;
    reg [1:0]  irqMask_r;
    reg [31:0] rdData_r;
    reg        ack_r;
    reg [4:0]  gnt_r;
    reg [4:0]  gnt_nxt;
    reg        trap_r;
    reg        irq_r;
    reg        brevAct_r;

    // Bus request decode
    wire       busReq = wb_cyc_i & wb_stb_i & ~ack_r;
    wire       wrEn   = busReq & wb_we_i;
    wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge a 16-bit write through the byte lanes
    function [15:0] lane_merge;
        input [15:0] oldVal;
        input [15:0] newVal;
        input [15:0] mask;
        begin
            lane_merge = (oldVal & ~mask) | (newVal & mask);
        end
    endfunction

    // Read multiplexer; unused upper bits and unmapped slots read zero
    function [31:0] read_word;
        input [5:0] adr;
        begin
            read_word = 32'h0000_0000;
            case ({adr[5:2], 2'b00})
                `DSPR_OFS_PRIO:    read_word = {16'h0000, prio_r};
                `DSPR_OFS_RDPAGE:  read_word = {22'h0, rdPage_r};
                `DSPR_OFS_WRPAGE:  read_word = {23'h0, wrPage_r};
                `DSPR_OFS_MODCTL:  read_word = {16'h0000, modCtl_r};
                `DSPR_OFS_IRQSTAT: read_word = {30'h0, irqStat_r};
                `DSPR_OFS_IRQMASK: read_word = {30'h0, irqMask_r};
                `DSPR_OFS_GRANT:   read_word = {27'h0, gnt_r};
                default:           read_word = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    endfunction

    // Address match, used by every register write
    function hit;
        input [5:0] adr;
        input [5:0] ofs;
        begin
            hit = (adr[5:2] == ofs[5:2]);
        end
    endfunction

    wire [15:0] prioNew  = lane_merge(prio_r, wb_dat_i[15:0], laneMask);
    wire [15:0] rdPgNew  = lane_merge({6'h00, rdPage_r}, wb_dat_i[15:0], laneMask);
    wire [15:0] wrPgNew  = lane_merge({7'h00, wrPage_r}, wb_dat_i[15:0], laneMask);
    wire [15:0] modNew   = lane_merge(modCtl_r, wb_dat_i[15:0], laneMask) & `DSPR_MOD_MASK;

    // ========================================
    // Software registers
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prio_r   <= `DSPR_RST_PRIO;
            rdPage_r <= `DSPR_RST_RDPAGE;
            wrPage_r <= `DSPR_RST_WRPAGE;
            modCtl_r <= `DSPR_RST_MODCTL;
            irqMask_r <= `DSPR_RST_IRQ;
        end
        else if (ce && wrEn)
        begin
            if (hit(wb_adr_i, `DSPR_OFS_PRIO))
                prio_r <= prioNew;
            if (hit(wb_adr_i, `DSPR_OFS_RDPAGE))
                rdPage_r <= rdPgNew[`DSPR_RDPAGE_W-1:0];
            if (hit(wb_adr_i, `DSPR_OFS_WRPAGE))
                wrPage_r <= wrPgNew[`DSPR_WRPAGE_W-1:0];
            if (hit(wb_adr_i, `DSPR_OFS_MODCTL))
                modCtl_r <= modNew;
            if (hit(wb_adr_i, `DSPR_OFS_IRQMASK) && wb_sel_i[0])
                irqMask_r <= wb_dat_i[1:0];
        end
    end

    // ========================================
    // Bus answer: ack one cycle after the request, then dropped
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r    <= 1'b0;
            rdData_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_r <= busReq;
            if (busReq && !wb_we_i)
            begin
                rdData_r <= read_word(wb_adr_i);
            end
        end
    end

    // ========================================
    // Grant selection; bits 1..3 of priority raise masters one..three above the core
    wire [3:1] raised = prio_r[3:1];
    wire       holdGnt = |(gnt_r & masterReq);

    always @*
    begin
        gnt_nxt = 5'h00;
        if (holdGnt)
            gnt_nxt = gnt_r; // Granted access keeps running under new priority
        else if (masterReq[1] && raised[1])
            gnt_nxt = 5'h02;
        else if (masterReq[2] && raised[2])
            gnt_nxt = 5'h04;
        else if (masterReq[3] && raised[3])
            gnt_nxt = 5'h08;
        else if (masterReq[0])
            gnt_nxt = 5'h01; // Core ahead of every unraised master
        else if (masterReq[1])
            gnt_nxt = 5'h02;
        else if (masterReq[2])
            gnt_nxt = 5'h04;
        else if (masterReq[3])
            gnt_nxt = 5'h08;
        else if (masterReq[4])
            gnt_nxt = 5'h10; // Debugger always last
    end

    // Grant register, a fresh request sees the priority as last written
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            gnt_r <= 5'h00;
        else if (ce)
            gnt_r <= gnt_nxt;
    end

    // ========================================
    // Page zero traps, checked against pointers in force at access start
    wire rdTrap = pageRdReq && (rdPage_r == {`DSPR_RDPAGE_W{1'b0}});
    wire wrTrap = pageWrReq && (wrPage_r == {`DSPR_WRPAGE_W{1'b0}});
    wire [1:0] trapEv = {wrTrap, rdTrap};
    wire [1:0] clrBits = (wrEn && hit(wb_adr_i, `DSPR_OFS_IRQSTAT) && wb_sel_i[0]) ?
                         wb_dat_i[1:0] : 2'h0;

    // Next status per event bit; the event beats a clear in the same cycle
    wire [1:0] statNxt;
    genvar sb;
    generate
        for (sb = 0; sb < 2; sb = sb + 1)
        begin : g_stat
            assign statNxt[sb] = trapEv[sb] | (irqStat_r[sb] & ~clrBits[sb]);
        end
    endgenerate

    // Sticky status, trap pulse and level interrupt
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStat_r <= `DSPR_RST_IRQ;
            trap_r    <= 1'b0;
            irq_r     <= 1'b0;
        end
        else if (ce)
        begin
            irqStat_r <= statNxt;
            trap_r    <= rdTrap | wrTrap;
            irq_r     <= |(statNxt & irqMask_r);
        end
    end

    // ========================================
    // Bit-reverse enable decode, all ones means off
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            brevAct_r <= 1'b0;
        else if (ce)
            brevAct_r <= (modCtl_r[`DSPR_MOD_BREV_HI:`DSPR_MOD_BREV_LO] != `DSPR_BREV_OFF);
    end

    // ========================================
    // Operating notes
    // Bus timing
    //   A request is taken on the first edge with cycle and strobe
    //   high, acknowledge low and the clock enable high.
    //   Acknowledge rises on that edge and falls on the next one.
    //   Writes land on the taking edge, the same edge on which
    //   acknowledge rises; a read word is captured there too.
    //   Masking busReq with ack_r stops a held request from
    //   landing twice while the master has not yet let go.
    //   Read data holds until the next read, so a slow master
    //   may still pick it up after acknowledge has gone.
    //   Only byte lanes 0 and 1 matter; no register is wider than 16 bits.
    //   Lanes 2 and 3 are ignored rather than refused.
    // Unmapped slots
    //   They answer like any register, read zero and drop writes.
    //   A stray access therefore never stalls the bus.
    // Clock enable
    //   While it is low nothing moves, acknowledge included.
    //   A master that waits for acknowledge simply waits longer.
    //   Trap requests seen during that time are not counted.
    // Page pointers
    //   Both reset to page one so that early paged accesses work
    //   without software set-up.
    //   Unimplemented upper bits are dropped on write and read zero.
    //   A pointer written on an edge is used from the next edge on;
    //   an access sampled on the writing edge still sees the old one.
    // Page zero traps
    //   The trap is a one-cycle pulse per trapping access cycle.
    //   A request held for several cycles keeps the trap high for that many cycles.
    //   The read and write checks are independent; both may fire
    //   in one cycle and then set both status bits.
    //   Status bits stay set until software writes a one to them.
    //   A trap in the clearing cycle leaves its bit set, so no
    //   event can be lost between reading and clearing status.
    // Interrupt
    //   The level output follows status on the same edge and mask one edge late.
    //   Changing the mask shows on the edge after the mask write.
    //   The line stays high while any unmasked bit is set.
    // Arbiter
    //   Grants are registered and one-hot, or zero when idle.
    //   A grant stands while its request stays high, whatever
    //   priority value is written meanwhile.
    //   When the request drops a new winner is picked on that edge.
    //   Priority bits 1 to 3 raise masters one to three above the
    //   core; the remaining bits are stored but steer nothing.
    //   Raised masters keep their fixed order among themselves, as
    //   do those left below the core.
    //   The debugger master can never be raised and comes last.
    //   A long holder can starve the others; that is the price of
    //   never cutting an access that has been granted.
    // Addressing control
    //   Bits 13 and 12 are unimplemented and read zero.
    //   The field outputs are wired straight from the register
    //   flops, so they change on the write edge.
    //   The bit-reverse active flag is registered from the select
    //   field and so trails a write by one cycle.
    //   The all-ones select code means bit-reversed addressing off.
    //   The modulo selects are passed on without any decoding here.
    // Reset
    //   The reset is asynchronous; all flops take constants only.
    //   Release should come well clear of an edge, as usual.
    // Limitations
    //   No parity or protection on the register bus.
    //   No error response; every access is acknowledged.

    // ========================================
    // Outputs, all taken from flip-flops
    assign wb_dat_o             = rdData_r;
    assign wb_ack_o             = ack_r;
    assign masterGnt            = gnt_r;
    assign addrErrTrap          = trap_r;
    assign readPage             = rdPage_r;
    assign writePage            = wrPage_r;
    assign xModuloEnable        = modCtl_r[`DSPR_MOD_XEN_BIT];
    assign yModuloEnable        = modCtl_r[`DSPR_MOD_YEN_BIT];
    assign bitrevPointerSelect  = modCtl_r[`DSPR_MOD_BREV_HI:`DSPR_MOD_BREV_LO];
    assign bitrevActive         = brevAct_r;
    assign yModuloPointerSelect = modCtl_r[`DSPR_MOD_YSEL_HI:`DSPR_MOD_YSEL_LO];
    assign xModuloPointerSelect = modCtl_r[`DSPR_MOD_XSEL_HI:`DSPR_MOD_XSEL_LO];
    assign irq                  = irq_r;

endmodule // dspr_regs

// ### verification/dspr_regs_asserts.sv
`timescale 1ns/1ps
// ========================================
// Port checks for the register bank
module dspr_regs_chk
(
    input wire       mclk,                // Clock
    input wire       rstn,                // Reset, low
    input wire       ce,                  // Enable
    input wire       wb_cyc_i,            // Cycle
    input wire       wb_stb_i,            // Strobe
    input wire       wb_ack_o,            // Ack
    input wire [4:0] masterReq,           // Requests
    input wire [4:0] masterGnt,           // Grant
    input wire       pageRdReq,           // Paged read
    input wire       pageWrReq,           // Paged write
    input wire       addrErrTrap,         // Trap
    input wire [9:0] readPage,            // Read page
    input wire [8:0] writePage,           // Write page
    input wire [3:0] bitrevPointerSelect, // Selector
    input wire       bitrevActive         // Selector in use
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_ackNext; (wb_cyc_i && wb_stb_i && !wb_ack_o && ce) |=> wb_ack_o; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack late");
    property p_rdTrap; (pageRdReq && readPage == 10'h000 && ce) |=> addrErrTrap; endproperty
    a_rdTrap: assert property (p_rdTrap) else $error("no read trap");
    property p_wrTrap; (pageWrReq && writePage == 9'h000 && ce) |=> addrErrTrap; endproperty
    a_wrTrap: assert property (p_wrTrap) else $error("no write trap");
    property p_noTrap;
        (ce && !(pageRdReq && readPage == 10'h000) && !(pageWrReq && writePage == 9'h000)) |=> !addrErrTrap;
    endproperty
    a_noTrap: assert property (p_noTrap) else $error("false trap");
    // Off code held two cycles must clear the flag
    property p_brevOff; (bitrevPointerSelect == 4'hF && ce) ##1 (bitrevPointerSelect == 4'hF) |-> !bitrevActive;
    endproperty
    a_brevOff: assert property (p_brevOff) else $error("bitrev on");
    property p_gntOneHot; $onehot0(masterGnt); endproperty
    a_gntOneHot: assert property (p_gntOneHot) else $error("grant not onehot");
    property p_gntReq; ce |=> ((masterGnt & ~$past(masterReq)) == 5'h00); endproperty
    a_gntReq: assert property (p_gntReq) else $error("grant without request");
    property p_gntHold; (masterGnt != 5'h00 && (masterGnt & masterReq) == masterGnt && ce) |=> $stable(masterGnt);
    endproperty
    a_gntHold: assert property (p_gntHold) else $error("grant lost");
    property p_pageRst; $rose(rstn) |-> (readPage == 10'h001 && writePage == 9'h001); endproperty
    a_pageRst: assert property (p_pageRst) else $error("page reset");
    c_trap: cover property (addrErrTrap);
    c_handover: cover property (masterGnt != 5'h00 ##1 masterGnt != $past(masterGnt) && masterGnt != 5'h00);
    c_brev: cover property (bitrevActive);
endmodule // dspr_regs_chk

bind dspr_regs dspr_regs_chk u_chk (.mclk(mclk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .masterReq(masterReq), .masterGnt(masterGnt), .pageRdReq(pageRdReq),
    .pageWrReq(pageWrReq), .addrErrTrap(addrErrTrap), .readPage(readPage), .writePage(writePage),
    .bitrevPointerSelect(bitrevPointerSelect), .bitrevActive(bitrevActive));

// ### verification/tb_data_space_page_priority_regs.sv
`timescale 1ns/1ps
// ========================================
// Bench for page and priority registers
module tb_data_space_page_priority_regs;
    reg         mclk, rstn, cyc, stb, we, rdReq, wrReq;
    reg  [5:0]  adr;
    reg  [31:0] datI, rd;
    reg  [4:0]  req;
    wire [31:0] datO;
    wire        ack, trap, xEn, yEn, brevOn, irq;
    wire [4:0]  gnt;
    wire [9:0]  rPage;
    wire [8:0]  wPage;
    wire [3:0]  bSel, ySel, xSel;
    integer     failures, samples_checked, cycles, i;
    dspr_regs DUT (.mclk(mclk), .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .masterReq(req),
        .masterGnt(gnt), .pageRdReq(rdReq), .pageWrReq(wrReq), .addrErrTrap(trap), .readPage(rPage),
        .writePage(wPage), .xModuloEnable(xEn), .yModuloEnable(yEn), .bitrevPointerSelect(bSel),
        .bitrevActive(brevOn), .yModuloPointerSelect(ySel), .xModuloPointerSelect(xSel), .irq(irq));
    task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("BAD %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // One classic cycle; waits past the edge where an old ack drops
    task wb(input w, input [5:0] a, input [31:0] d);
    begin
        @(posedge mclk);
        {cyc, stb, we, adr, datI} <= {2'b11, w, a, d};
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        rd = datO;
        {cyc, stb, we} <= 3'b000;
    end
    endtask
    task do_reset;
    begin
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
    end
    endtask
    // Reset value, then all ones, for priority, both page and mode registers and one unmapped slot
    task t_regs;
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            wb(0, {6'h1C, 6'h0C, 6'h08, 6'h04, 6'h00} >> (i * 6), 0);
            check("rstval", rd, ({16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000} >> (i * 16)) & 80'hFFFF);
            wb(1, {6'h1C, 6'h0C, 6'h08, 6'h04, 6'h00} >> (i * 6), 32'hFFFFFFFF);
            wb(0, {6'h1C, 6'h0C, 6'h08, 6'h04, 6'h00} >> (i * 6), 0);
            check("rdback", rd, ({16'h0000, 16'hCFFF, 16'h01FF, 16'h03FF, 16'hFFFF} >> (i * 16)) & 80'hFFFF);
        end
    end
    endtask
    task t_brev(input [3:0] s);
    begin
        wb(1, 6'h0C, {20'h0, s, 8'h00});
        repeat (2) @(negedge mclk);
        check("brev", {bSel, brevOn}, {s, s != 4'hF});
    end
    endtask
    task pulse(input isWr, input expT);
    begin
        @(posedge mclk);
        {rdReq, wrReq} <= {!isWr, isWr};
        @(posedge mclk);
        {rdReq, wrReq} <= 2'b00;
        @(negedge mclk);
        check("trap", trap, expT);
    end
    endtask
    // Zero page traps, sets status and irq; mask and clear irq
    task t_trap(input isWr);
    begin
        wb(1, isWr ? 6'h08 : 6'h04, 0);
        pulse(isWr, 1);
        check("irq", irq, 1);
        wb(0, 6'h10, 0);
        check("status", rd, isWr ? 2 : 1);
        wb(1, 6'h14, 0);
        @(negedge mclk);
        check("masked", irq, 0);
        wb(1, 6'h14, 3);
        wb(1, 6'h10, 3);
        @(negedge mclk);
        check("cleared", irq, 0);
        wb(1, isWr ? 6'h08 : 6'h04, 1);
        pulse(isWr, 0);
    end
    endtask
    task t_arb(input [15:0] prio, input [24:0] seq);
    begin
        wb(1, 6'h00, prio);
        req <= 5'h1F;
        for (i = 0; i < 5; i = i + 1)
        begin
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            check("gnt", gnt, seq[i*5+:5]);
            @(posedge mclk);
            req <= req & ~seq[i*5+:5];
        end
    end
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            print_verdict;
        end
    end
    initial
    begin
        {cyc, stb, we, rdReq, wrReq, adr, datI, req} = 0;
        {failures, samples_checked, cycles} = 0;
        do_reset;
        t_regs;
        check("modpins", {xEn, yEn, ySel, xSel, brevOn}, 11'h7FE);
        do_reset;
        @(negedge mclk);
        check("pages", {rPage, wPage}, {10'h001, 9'h001});
        t_brev(4'hF);
        t_brev(4'h3);
        wb(1, 6'h14, 3);
        t_trap(0);
        t_trap(1);
        t_arb(16'h0000, {5'h10, 5'h08, 5'h04, 5'h02, 5'h01});
        t_arb(16'h000E, {5'h10, 5'h01, 5'h08, 5'h04, 5'h02});
        t_arb(16'h0008, {5'h10, 5'h04, 5'h02, 5'h01, 5'h08});
        wb(1, 6'h00, 0);
        req <= 5'h03;
        wb(1, 6'h00, 2);
        @(negedge mclk);
        check("hold", gnt, 5'h01);
        wb(0, 6'h18, 0);
        check("gntreg", rd, 1);
        @(posedge mclk);
        req <= 5'h00;
        @(posedge mclk);
        req <= 5'h03;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check("next", gnt, 5'h02);
        print_verdict;
    end
endmodule // tb_data_space_page_priority_regs
